// ### pdss_params.svh
`ifndef PDSS_PARAMS_SVH
`define PDSS_PARAMS_SVH
`define PDSS_AREA_BASE 7'h40
`define PDSS_AREA_LAST 7'h7f
`define PDSS_SLOT_BYTES 7'h08
`define PDSS_BYTE_SP1_HI 3'h0
`define PDSS_BYTE_SP1_LO 3'h1
`define PDSS_BYTE_DIAG 3'h1
`define PDSS_BYTE_POS_HI 3'h2
`define PDSS_BYTE_POS_LO 3'h3
`define PDSS_BYTE_SP2_HI 3'h2
`define PDSS_BYTE_SP2_LO 3'h3
`define PDSS_DIAG_SYNC 0
`define PDSS_DIAG_S1 1
`define PDSS_DIAG_S2 2
`define PDSS_DIAG_OVF 3
`define PDSS_SP_RESET 16'h0000
`define PDSS_POS_RESET 16'h0000
`define PDSS_POS_MAX 16'h7fff
`define PDSS_POS_MIN 16'h8000
`endif

// ### pdss_pkg.sv
package pdss_pkg;
  typedef logic [15:0] pdss_word_type;
  typedef enum logic [1:0] {PDSS_HOLD, PDSS_UP, PDSS_DOWN} pdss_dir_type;
endpackage

// ### pdss_switch.sv
// How it works
// RL1: Set output stays on until enable low
// RL2: Direction reversal does not clear output
// RL3: Leaving signed range sets overflow bit 3
// RL4: Overflow blocks new output switch-on
// RL5: Overflow keeps outputs and sync bit
// RL6: Controller drops enable after overflow
// RL7: New sync clears overflow, re-enables outputs
// RL8: Setpoint writes always taken, applied when off
// RL9: Diag bits 1,2 show reached and on
// RL10: Reached flag zero: new setpoint immediate
// RL11: Reached flag one: wait enable rise
// RL12: Enable fall clears outputs and flags
// RL13: Controller writes, drops, raises enable
// RL14: Reaching new setpoints sets output again
// RL15: Slot n at byte 64 plus 8n
// RL16: Four data bytes, high byte first
// RL17: Sync state readable as diag bit 0
// RL18: Set only synced, enabled, position equal
// RL19: Count up positive, down negative
// RL20: Position is signed 16-bit value
// RL21: Compare checked on every count step
`timescale 1ns/1ps
`include "pdss_params.svh"
module pdss_switch #(
  parameter int SLOT = 0,
  parameter int SLOTS = 8
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic count_up_in,
  input wire logic count_down_in,
  input wire logic sync_done_in,
  input wire logic enable_in,
  input wire logic [6:0] input_process_image_addr_in,
  output logic [7:0] input_process_image_data_out,
  input wire logic output_process_image_wr_in,
  input wire logic [6:0] output_process_image_addr_in,
  input wire logic [7:0] output_process_image_data_in,
  output logic out1_out,
  output logic out2_out,
  output logic synced_out,
  output logic overflow_out
);
  import pdss_pkg::*;

  // Elaboration refuses a slot that falls outside the byte area
  if (SLOT < 0 || SLOT >= SLOTS || SLOTS > 8) begin : gen_slot_check
    $error("Slot outside address area");
  end

  localparam logic [6:0] SLOT_BASE =
    7'(`PDSS_AREA_BASE + 7'(SLOT) * `PDSS_SLOT_BYTES); // see RL15

  // True when the address hits byte b of this slot's eight-byte window
  function automatic logic hit(input logic [6:0] a, input logic [2:0] b);
    hit = (a >= `PDSS_AREA_BASE) && (a[6:3] == SLOT_BASE[6:3]) && (a[2:0] == b); // see RL16
  endfunction

  pdss_word_type pos_r, sp1_r, sp2_r, new1_r, new2_r;
  logic pend1_r, pend2_r, en_q_r, ovf_r, sync_r, s1_r, s2_r;
  logic [7:0] sp1_hi_r, sp2_hi_r;
  pdss_dir_type dir;

  wire en_rise = enable_in && !en_q_r;
  wire en_fall = !enable_in && en_q_r;

  always_comb begin
    if (count_up_in && !count_down_in) begin
      dir = PDSS_UP;
    end else if (count_down_in && !count_up_in) begin
      dir = PDSS_DOWN;
    end else begin
      dir = PDSS_HOLD;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_q_r <= 1'b0;
    end else begin
      en_q_r <= enable_in;
    end
  end

  // Position counter; sync resets it to zero
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pos_r <= `PDSS_POS_RESET;
    end else if (sync_done_in) begin
      pos_r <= `PDSS_POS_RESET;
    end else begin
      case (dir)
        PDSS_UP: pos_r <= pos_r + 16'h0001; // see RL19
        PDSS_DOWN: pos_r <= pos_r - 16'h0001; // see RL19
        default: pos_r <= pos_r;
      endcase
    end
  end

  // Overflow and sync flags
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ovf_r <= 1'b0;
      sync_r <= 1'b0;
    end else if (sync_done_in) begin
      ovf_r <= 1'b0; // see RL7
      sync_r <= 1'b1;
    end else if ((dir == PDSS_UP && pos_r == `PDSS_POS_MAX) ||
                 (dir == PDSS_DOWN && pos_r == `PDSS_POS_MIN)) begin
      ovf_r <= 1'b1; // see RL3
    end
  end

  // Setpoint writes: high byte latched, low byte commits the word
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sp1_hi_r <= 8'h00;
      sp2_hi_r <= 8'h00;
    end else if (output_process_image_wr_in) begin
      if (hit(output_process_image_addr_in, `PDSS_BYTE_SP1_HI)) begin
        sp1_hi_r <= output_process_image_data_in;
      end
      if (hit(output_process_image_addr_in, `PDSS_BYTE_SP2_HI)) begin
        sp2_hi_r <= output_process_image_data_in;
      end
    end
  end

  wire wr1 = output_process_image_wr_in && hit(output_process_image_addr_in, `PDSS_BYTE_SP1_LO);
  wire wr2 = output_process_image_wr_in && hit(output_process_image_addr_in, `PDSS_BYTE_SP2_LO);

  // Effective setpoints; pending value waits for enable rise while on
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sp1_r <= `PDSS_SP_RESET;
      sp2_r <= `PDSS_SP_RESET;
      new1_r <= `PDSS_SP_RESET;
      new2_r <= `PDSS_SP_RESET;
      pend1_r <= 1'b0;
      pend2_r <= 1'b0;
    end else begin
      if (wr1 && !s1_r) begin
        sp1_r <= {sp1_hi_r, output_process_image_data_in}; // see RL10
        pend1_r <= 1'b0;
      end else if (wr1) begin
        new1_r <= {sp1_hi_r, output_process_image_data_in}; // see RL8
        pend1_r <= 1'b1;
      end else if (pend1_r && en_rise) begin
        sp1_r <= new1_r; // see RL11
        pend1_r <= 1'b0;
      end
      if (wr2 && !s2_r) begin
        sp2_r <= {sp2_hi_r, output_process_image_data_in}; // see RL10
        pend2_r <= 1'b0;
      end else if (wr2) begin
        new2_r <= {sp2_hi_r, output_process_image_data_in}; // see RL8
        pend2_r <= 1'b1;
      end else if (pend2_r && en_rise) begin
        sp2_r <= new2_r; // see RL11
        pend2_r <= 1'b0;
      end
    end
  end

  // Compare on current count each clock so no step is missed
  wire arm = sync_r && !ovf_r && enable_in && !en_fall; // see RL18
  wire hit1 = arm && pos_r == sp1_r && !pend1_r; // see RL21
  wire hit2 = arm && pos_r == sp2_r && !pend2_r; // see RL4

  // Only enable low clears; reversal and overflow leave outputs on
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else if (!enable_in) begin
      s1_r <= 1'b0; // see RL12
      s2_r <= 1'b0; // see RL1
    end else begin
      s1_r <= s1_r || hit1; // see RL2
      s2_r <= s2_r || hit2; // see RL14
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      input_process_image_data_out <= 8'h00;
    end else if (hit(input_process_image_addr_in, `PDSS_BYTE_DIAG)) begin
      input_process_image_data_out <= {4'h0, ovf_r, s2_r, s1_r, sync_r}; // see RL9
    end else if (hit(input_process_image_addr_in, `PDSS_BYTE_POS_HI)) begin
      input_process_image_data_out <= pos_r[15:8]; // see RL20
    end else if (hit(input_process_image_addr_in, `PDSS_BYTE_POS_LO)) begin
      input_process_image_data_out <= pos_r[7:0];
    end else begin
      input_process_image_data_out <= 8'h00;
    end
  end

  assign out1_out = s1_r;
  assign out2_out = s2_r;
  assign synced_out = sync_r; // see RL17
  assign overflow_out = ovf_r; // see RL5

  // Output switching
  chk_enable_low_clears: assert property ( // see RL12
    @(posedge clock_in) disable iff (!arst_n_in)
    !enable_in |=> !s1_r && !s2_r) else $error("Outputs on after enable low");

  chk_hold_while_enabled: assert property ( // see RL1
    @(posedge clock_in) disable iff (!arst_n_in)
    s1_r && enable_in |=> s1_r) else $error("Output 1 dropped while enabled");

  chk_hold_out_two: assert property ( // see RL1
    @(posedge clock_in) disable iff (!arst_n_in)
    s2_r && enable_in |=> s2_r) else $error("Output 2 dropped while enabled");

  chk_reversal_keeps: assert property ( // see RL2
    @(posedge clock_in) disable iff (!arst_n_in)
    s1_r && enable_in && dir == PDSS_DOWN |=> s1_r) else $error("Reversal cleared output 1");

  chk_no_new_on_ovf: assert property ( // see RL4
    @(posedge clock_in) disable iff (!arst_n_in)
    ovf_r && !s2_r |=> !s2_r) else $error("Output 2 set during overflow");

  chk_no_new_ovf_one: assert property ( // see RL4
    @(posedge clock_in) disable iff (!arst_n_in)
    ovf_r && !s1_r |=> !s1_r) else $error("Output 1 set during overflow");

  chk_ovf_keeps_out: assert property ( // see RL5
    @(posedge clock_in) disable iff (!arst_n_in)
    ovf_r && s1_r && enable_in |=> s1_r) else $error("Overflow cleared output 1");

  chk_set_on_equal: assert property ( // see RL18
    @(posedge clock_in) disable iff (!arst_n_in)
    hit1 && enable_in |=> s1_r) else $error("Setpoint 1 hit not taken");

  chk_set2_on_equal: assert property ( // see RL14
    @(posedge clock_in) disable iff (!arst_n_in)
    hit2 |=> s2_r) else $error("Setpoint 2 hit not taken");

  chk_s1_needs_arm: assert property ( // see RL18
    @(posedge clock_in) disable iff (!arst_n_in)
    !s1_r && !hit1 |=> !s1_r) else $error("Output 1 set without a hit");

  chk_s2_needs_arm: assert property ( // see RL18
    @(posedge clock_in) disable iff (!arst_n_in)
    !s2_r && !hit2 |=> !s2_r) else $error("Output 2 set without a hit");

  chk_no_set_unsynced: assert property ( // see RL18
    @(posedge clock_in) disable iff (!arst_n_in)
    !sync_r && !s1_r |=> !s1_r) else $error("Output 1 set while not synced");

  chk_s2_unsynced: assert property ( // see RL18
    @(posedge clock_in) disable iff (!arst_n_in)
    !sync_r && !s2_r |=> !s2_r) else $error("Output 2 set while not synced");

  // Counting, overflow and sync
  chk_count_up: assert property ( // see RL19
    @(posedge clock_in) disable iff (!arst_n_in)
    dir == PDSS_UP && !sync_done_in |=> pos_r == $past(pos_r) + 16'h0001)
    else $error("Count did not step up");

  chk_count_down: assert property ( // see RL19
    @(posedge clock_in) disable iff (!arst_n_in)
    dir == PDSS_DOWN && !sync_done_in |=> pos_r == $past(pos_r) - 16'h0001)
    else $error("Count did not step down");

  chk_count_hold: assert property ( // see RL19
    @(posedge clock_in) disable iff (!arst_n_in)
    dir == PDSS_HOLD && !sync_done_in |=> pos_r == $past(pos_r))
    else $error("Count moved without a step");

  chk_ovf_at_top: assert property ( // see RL3
    @(posedge clock_in) disable iff (!arst_n_in)
    dir == PDSS_UP && pos_r == 16'h7fff && !sync_done_in |=> ovf_r) else $error("Overflow missed");

  chk_ovf_at_bottom: assert property ( // see RL3
    @(posedge clock_in) disable iff (!arst_n_in)
    dir == PDSS_DOWN && pos_r == 16'h8000 && !sync_done_in |=> ovf_r)
    else $error("Underflow missed");

  chk_ovf_only_edge: assert property ( // see RL3
    @(posedge clock_in) disable iff (!arst_n_in)
    !ovf_r && !(dir == PDSS_UP && pos_r == 16'h7fff) && !(dir == PDSS_DOWN && pos_r == 16'h8000)
    |=> !ovf_r) else $error("Overflow set inside range");

  chk_ovf_sticky: assert property ( // see RL7
    @(posedge clock_in) disable iff (!arst_n_in)
    ovf_r && !sync_done_in |=> ovf_r) else $error("Overflow cleared without sync");

  chk_sync_clears_ovf: assert property ( // see RL7
    @(posedge clock_in) disable iff (!arst_n_in)
    sync_done_in |=> !ovf_r && sync_r && pos_r == 16'h0000) else $error("Sync did not clear");

  chk_sync_kept_ovf: assert property ( // see RL5
    @(posedge clock_in) disable iff (!arst_n_in)
    sync_r && !sync_done_in |=> sync_r) else $error("Sync bit dropped");

  chk_no_early_sync: assert property ( // see RL17
    @(posedge clock_in) disable iff (!arst_n_in)
    !sync_r && !sync_done_in |=> !sync_r) else $error("Sync bit set without sync");

  // Setpoint acceptance
  chk_immediate_load: assert property ( // see RL10
    @(posedge clock_in) disable iff (!arst_n_in)
    wr1 && !s1_r |=> sp1_r == {$past(sp1_hi_r), $past(output_process_image_data_in)})
    else $error("Setpoint 1 not immediate");

  chk_immediate_two: assert property ( // see RL10
    @(posedge clock_in) disable iff (!arst_n_in)
    wr2 && !s2_r |=> sp2_r == {$past(sp2_hi_r), $past(output_process_image_data_in)})
    else $error("Setpoint 2 not immediate");

  chk_write_while_on: assert property ( // see RL8
    @(posedge clock_in) disable iff (!arst_n_in)
    wr1 && s1_r |=> pend1_r && sp1_r == $past(sp1_r)) else $error("Setpoint 1 taken while on");

  chk_write2_while_on: assert property ( // see RL8
    @(posedge clock_in) disable iff (!arst_n_in)
    wr2 && s2_r |=> pend2_r && sp2_r == $past(sp2_r)) else $error("Setpoint 2 taken while on");

  chk_pending_holds: assert property ( // see RL8
    @(posedge clock_in) disable iff (!arst_n_in)
    pend1_r && !en_rise && !wr1 |=> pend1_r && sp1_r == $past(sp1_r))
    else $error("Pending setpoint 1 applied early");

  chk_pend2_holds: assert property ( // see RL8
    @(posedge clock_in) disable iff (!arst_n_in)
    pend2_r && !en_rise && !wr2 |=> pend2_r && sp2_r == $past(sp2_r))
    else $error("Pending setpoint 2 applied early");

  chk_no_write_steady: assert property ( // see RL8
    @(posedge clock_in) disable iff (!arst_n_in)
    !wr1 && !(pend1_r && en_rise) |=> sp1_r == $past(sp1_r)) else $error("Setpoint 1 drifted");

  chk_pending_on_rise: assert property ( // see RL11
    @(posedge clock_in) disable iff (!arst_n_in)
    pend1_r && en_rise && !wr1 |=> sp1_r == $past(new1_r) && !pend1_r)
    else $error("Pending setpoint not applied");

  chk_pending_two: assert property ( // see RL11
    @(posedge clock_in) disable iff (!arst_n_in)
    pend2_r && en_rise && !wr2 |=> sp2_r == $past(new2_r) && !pend2_r)
    else $error("Pending setpoint 2 not applied");

  // Read side of the byte window
  chk_diag_layout: assert property ( // see RL9
    @(posedge clock_in) disable iff (!arst_n_in)
    hit(input_process_image_addr_in, `PDSS_BYTE_DIAG) |=> input_process_image_data_out ==
      {4'h0, $past(ovf_r), $past(s2_r), $past(s1_r), $past(sync_r)})
    else $error("Diagnostic byte wrong");

  chk_pos_high_byte: assert property ( // see RL16
    @(posedge clock_in) disable iff (!arst_n_in)
    hit(input_process_image_addr_in, `PDSS_BYTE_POS_HI) |=>
      input_process_image_data_out == $past(pos_r[15:8])) else $error("Position high byte wrong");

  chk_pos_low_byte: assert property ( // see RL16
    @(posedge clock_in) disable iff (!arst_n_in)
    hit(input_process_image_addr_in, `PDSS_BYTE_POS_LO) |=>
      input_process_image_data_out == $past(pos_r[7:0])) else $error("Position low byte wrong");

  chk_unused_read_zero: assert property ( // see RL16
    @(posedge clock_in) disable iff (!arst_n_in)
    !hit(input_process_image_addr_in, `PDSS_BYTE_DIAG) &&
    !hit(input_process_image_addr_in, `PDSS_BYTE_POS_HI) &&
    !hit(input_process_image_addr_in, `PDSS_BYTE_POS_LO) |=> input_process_image_data_out == 8'h00)
    else $error("Unused byte not zero");

  chk_other_area_read: assert property ( // see RL15
    @(posedge clock_in) disable iff (!arst_n_in)
    input_process_image_addr_in < `PDSS_AREA_BASE |=> input_process_image_data_out == 8'h00)
    else $error("Read below area answered");
endmodule

// ### pdss_encoder.sv
`timescale 1ns/1ps
module pdss_encoder (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic start_in,
  input wire logic up_in,
  input wire logic slow_in,
  input wire logic [16:0] steps_in,
  input wire logic sync_req_in,
  output logic count_up_out,
  output logic count_down_out,
  output logic sync_done_out,
  output logic busy_out
);
  logic [16:0] left_r;
  logic dir_r;
  logic ph_r;
  logic go;
  // Slow mode leaves a quiet cycle between steps, like a crawling axis
  assign go = (left_r != 17'h00000) && !(slow_in && ph_r);
  assign count_up_out = go && dir_r;
  assign count_down_out = go && !dir_r;
  assign busy_out = left_r != 17'h00000;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      left_r <= 17'h00000;
      dir_r <= 1'b0;
      ph_r <= 1'b0;
      sync_done_out <= 1'b0;
    end else begin
      ph_r <= ~ph_r;
      sync_done_out <= sync_req_in;
      if (start_in) begin
        left_r <= steps_in;
        dir_r <= up_in;
      end else if (go) begin
        left_r <= left_r - 17'h00001;
      end
    end
  end
endmodule

// ### pdss_switch_bench.sv
`timescale 1ns/1ps
module pdss_switch_bench;
  import pdss_pkg::*;
  logic clk = 0, rst_n = 0, en = 0, wr = 0, rv = 0, rd_d = 0, st = 0, up = 0, sreq = 0;
  logic slow = 0, cu, cd, sd, busy, o1, o2, sy, ov;
  logic [6:0] ra = 7'h40, wa = 7'h40;
  logic [7:0] wd = 8'h00, rdat;
  logic [16:0] n = 17'h00000;
  logic [7:0] q[$];
  pdss_word_type pos = 16'h0000, r;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  initial forever #25 clk = ~clk;
  pdss_switch pdss_switch_inst (.clock_in(clk), .arst_n_in(rst_n), .count_up_in(cu),
    .count_down_in(cd), .sync_done_in(sd), .enable_in(en), .input_process_image_addr_in(ra),
    .input_process_image_data_out(rdat), .output_process_image_wr_in(wr),
    .output_process_image_addr_in(wa), .output_process_image_data_in(wd), .out1_out(o1),
    .out2_out(o2), .synced_out(sy), .overflow_out(ov));
  pdss_encoder pdss_encoder_inst (.clock_in(clk), .arst_n_in(rst_n), .start_in(st),
    .up_in(up), .slow_in(slow), .steps_in(n), .sync_req_in(sreq), .count_up_out(cu),
    .count_down_out(cd), .sync_done_out(sd), .busy_out(busy));
  task check(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t saw %h expected %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Overflow run is about 33k cycles, so the ceiling sits well above it
  always @(posedge clk) begin
    cyc++;
    rd_d <= rv;
    if (cyc == 80000) begin
      error_cnt++;
      give_verdict;
    end
  end
  // Read data stands one cycle, so it is taken mid-cycle
  always @(negedge clk) if (rd_d) check({8'h00, rdat}, {8'h00, q.pop_front()});
  task wb(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk) #2 wr = 1;
    wa = a;
    wd = d;
    @(posedge clk) #2 wr = 0;
  endtask
  task sp(input logic [6:0] a, input pdss_word_type v);
    wb(a, v[15:8]);
    wb(a + 7'h01, v[7:0]);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk) #2 ra = a;
    rv = 1;
    q.push_back(e);
    @(posedge clk) #2 rv = 0;
  endtask
  task look(input logic [7:0] d);
    rd(7'h41, d);
    check({12'h000, o1, o2, sy, ov}, {12'h000, d[1], d[2], d[0], d[3]});
  endtask
  task mv(input logic u, input logic [16:0] k);
    @(posedge clk) #2 st = 1;
    up = u;
    n = k;
    pos = u ? pos + k[15:0] : pos - k[15:0];
    @(posedge clk) #2 st = 0;
    for (int i = 0; i < 70000 && busy === 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  task ena(input logic v);
    @(posedge clk) #2 en = v;
  endtask
  task sync;
    @(posedge clk) #2 sreq = 1;
    pos = 16'h0000;
    @(posedge clk) #2 sreq = 0;
    repeat (3) @(posedge clk);
  endtask
  initial begin
    r = 16'($urandom(20));
    r = 16'($urandom % 40 + 10);
    repeat (20) @(posedge clk);
    #2 rst_n = 1;
    look(8'h00);
    sync;
    look(8'h01);
    sp(7'h40, r);
    sp(7'h42, 16'hfffe);
    ena(1);
    mv(1, {1'b0, r}); look(8'h03);
    mv(1, 17'h00003); look(8'h03);
    slow = 1;
    mv(0, {1'b0, r + 16'h0005}); look(8'h07);
    slow = 0;
    rd(7'h42, pos[15:8]);
    rd(7'h43, pos[7:0]);
    sp(7'h40, 16'h0005);
    sp(7'h42, 16'h0009);
    ena(0); look(8'h01);
    ena(1); look(8'h01);
    mv(1, {1'b0, r + 16'h0002}); look(8'h07);
    mv(1, 17'h08000 - {1'b0, r}); look(8'h0f);
    ena(0); look(8'h09);
    sp(7'h40, 16'h7ffe);
    ena(1);
    mv(0, 17'h00002); look(8'h09);
    sync; look(8'h01);
    mv(1, 17'h00009); look(8'h05);
    sp(7'h48, 16'h0009);
    sp(7'h44, 16'h0009);
    look(8'h05);
    rd(7'h40, 8'h00);
    rd(7'h44, 8'h00);
    rd(7'h49, 8'h00);
    sp(7'h40, 16'h000b);
    mv(1, 17'h00002); look(8'h07);
    give_verdict;
  end
endmodule
